// [src/dmsp_pkg.sv]
package dmsp_pkg;

   // ****************************************
   // register map and reset values
   // ****************************************
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_STATUS  = 8'h04;
   localparam logic [7:0]  REG_COUNT   = 8'h08;
   localparam logic [1:0]  CTRL_RST    = 2'h0;
   localparam logic [15:0] COUNT_RST   = 16'h0000;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // status field positions
   localparam int STS_LOCK  = 0;
   localparam int STS_HOLD  = 1;
   localparam int STS_FAIL  = 2;   // three bits, input a first
   localparam int STS_STATE = 5;   // two bits
   localparam int STS_REF   = 7;   // two bits
   localparam int STS_MODE  = 9;   // two bits
   localparam int STS_APP   = 11;  // two bits
   localparam int STS_HIT   = 13;

   // ****************************************
   // pin encodings and monitor limits
   // ****************************************
   localparam int          NUM_REF     = 3;
   localparam logic [1:0]  MODE_NORMAL = 2'h0;
   localparam logic [1:0]  MODE_HOLD   = 2'h1;
   localparam logic [1:0]  MODE_FREE   = 2'h2;
   localparam logic [1:0]  MODE_AUTO   = 2'h3;
   localparam logic [1:0]  APP_DS1     = 2'h0;
   localparam logic [1:0]  APP_E1      = 2'h1;
   localparam logic [15:0] THR_DS1     = 16'h0190;
   localparam logic [15:0] THR_E1      = 16'h01F4;
   localparam logic [15:0] THR_WIDE    = 16'h0320;

   typedef enum logic [1:0] {ST_FREE, ST_NORM, ST_HOLD} dmsp_state_e;

endpackage

// [src/dmsp_mon_if.sv]
`timescale 1ns/1ps
// one reference monitor: measured offset in, failure flag out
interface dmsp_mon_if;
   logic signed [15:0] offset;
   logic               abrupt;
   logic        [15:0] thr;
   logic               fail;
   modport mon  (input offset, input abrupt, input thr, output fail);
   modport core (output offset, output abrupt, output thr, input fail);
endinterface

// [src/dmsp_ref_mon.sv]
`timescale 1ns/1ps
module dmsp_ref_mon
   import dmsp_pkg::*;
(
   input wire logic clk_i,     // master clock
   input wire logic sys_rst_i, // sync reset, high
   dmsp_mon_if.mon  m          // monitor signals
);

   logic [16:0] mag;
   logic        fail_d;
   logic        fail_q;

   // ****************************************
   // out-of-range and abrupt-change check
   // ****************************************
   // 17 bits so the most negative offset still has a magnitude
   always_comb
   begin
      mag    = m.offset[15] ? (17'h0 - {1'b1, m.offset})
                            : {1'b0, m.offset};
      fail_d = m.abrupt || (mag > {1'b0, m.thr});
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         fail_q <= 1'b0;
      else
         fail_q <= fail_d;
   end

   assign m.fail = fail_q;

   // ****************************************
   // checks
   // ****************************************
   chk_abrupt_flag: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      m.abrupt |=> m.fail)
      else $error("abrupt change did not raise the flag");

   chk_clean_clear: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      (!m.abrupt && mag <= {1'b0, m.thr}) |=> !m.fail)
      else $error("flag high for an in-range steady input");

endmodule

// [src/dmsp_top.sv]
`timescale 1ns/1ps
// Function
// - lock high while locked to selected input
// - coast output high throughout holdover
// - per-input flag on range or abrupt change
// - hitless low keeps stored offset on a same-input return
// - hitless high remeasures offset on return
// - mode bits taken as one agreed pair
// - mode 11 picks references automatically
// - application 00 uses DS1 limits
// - application 01 uses E1 limits
module dmsp_top
   import dmsp_pkg::*;
(
   input  wire logic              clk_i,                // master clock
   input  wire logic              sys_rst_i,            // sync reset
   input  wire logic              op_mode_bit0_i,       // mode pin 0
   input  wire logic              op_mode_bit1_i,       // mode pin 1
   input  wire logic              application_bit0_i,   // app pin 0
   input  wire logic              application_bit1_i,   // app pin 1
   input  wire logic              hitless_return_ctl_i, // hitless pin
   input  wire logic              loop_locked_i,        // loop freq lock
   input  wire logic [2:0][15:0]  input_offset_i,       // signed offsets
   input  wire logic [2:0]        input_abrupt_i,       // abrupt change
   output logic                   loop_locked_o,        // lock pin
   output logic                   coast_mode_o,         // holdover pin
   output logic                   input_a_bad_flag_o,   // input a fail
   output logic                   input_b_bad_flag_o,   // input b fail
   output logic                   input_c_bad_flag_o,   // input c fail
   output logic [1:0]             active_input_o,       // selected input
   output logic                   offset_store_remeasure_o, // pulse
   input  wire logic [7:0]        s_axi_awaddr,         // write address
   input  wire logic              s_axi_awvalid,        // aw valid
   output logic                   s_axi_awready,        // aw ready
   input  wire logic [31:0]       s_axi_wdata,          // write data
   input  wire logic [3:0]        s_axi_wstrb,          // byte enables
   input  wire logic              s_axi_wvalid,         // w valid
   output logic                   s_axi_wready,         // w ready
   output logic [1:0]             s_axi_bresp,          // write resp
   output logic                   s_axi_bvalid,         // b valid
   input  wire logic              s_axi_bready,         // b ready
   input  wire logic [7:0]        s_axi_araddr,         // read address
   input  wire logic              s_axi_arvalid,        // ar valid
   output logic                   s_axi_arready,        // ar ready
   output logic [31:0]            s_axi_rdata,          // read data
   output logic [1:0]             s_axi_rresp,          // read resp
   output logic                   s_axi_rvalid,         // r valid
   input  wire logic              s_axi_rready          // r ready
);

   logic [1:0]  mode_s1_q, mode_s2_q, mode_s3_q, mode_q, mode_d;
   logic [1:0]  app_s1_q, app_q;
   logic        hit_s1_q, hit_q;
   logic [1:0]  pins_mode;
   dmsp_state_e st_q, st_d;
   logic [1:0]  ref_q, ref_d, sel, first_good;
   logic        lock_q, lock_d, hold_q, hold_d, meas_q, meas_d;
   logic [15:0] cnt_q, cnt_d, thr;
   logic [2:0]  fail_w;
   logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
   logic [7:0]  awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, sts;
   logic [3:0]  wstrb_q, wstrb_d;
   logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d, ctrl_q, ctrl_d;

   // ****************************************
   // pin synchronisers
   // ****************************************
   // second stage only feeds logic; mode gets a third stage to
   // check that both bits settled on the same value
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         mode_s1_q <= 2'h0;
         mode_s2_q <= 2'h0;
         mode_s3_q <= 2'h0;
         app_s1_q  <= 2'h0;
         app_q     <= 2'h0;
         hit_s1_q  <= 1'b0;
         hit_q     <= 1'b0;
      end
      else
      begin
         mode_s1_q <= {op_mode_bit1_i, op_mode_bit0_i};
         mode_s2_q <= mode_s1_q;
         mode_s3_q <= mode_s2_q;
         app_s1_q  <= {application_bit1_i, application_bit0_i};
         app_q     <= app_s1_q;
         hit_s1_q  <= hitless_return_ctl_i;
         hit_q     <= hit_s1_q;
      end
   end

   // ****************************************
   // reference monitors
   // ****************************************
   // limit chosen by the application pins
   always_comb
   begin
      case (app_q)
         APP_DS1: thr = THR_DS1;
         APP_E1:  thr = THR_E1;
         default: thr = THR_WIDE;
      endcase
   end

   dmsp_mon_if mon_if [NUM_REF] ();

   for (genvar g = 0; g < NUM_REF; g++)
   begin : g_mon
      assign mon_if[g].offset = input_offset_i[g];
      assign mon_if[g].abrupt = input_abrupt_i[g];
      assign mon_if[g].thr    = thr;
      assign fail_w[g]        = mon_if[g].fail;
      dmsp_ref_mon u_mon (
         .clk_i     (clk_i),
         .sys_rst_i (sys_rst_i),
         .m         (mon_if[g].mon)
      );
   end

   assign input_a_bad_flag_o = fail_w[0];
   assign input_b_bad_flag_o = fail_w[1];
   assign input_c_bad_flag_o = fail_w[2];

   // ****************************************
   // mode and reference state machine
   // ****************************************
   always_comb
   begin
      // a mode is accepted only once two samples agree
      mode_d = (mode_s2_q == mode_s3_q) ? mode_s2_q : mode_q;
      sel    = (ctrl_q == 2'h3) ? 2'h0 : ctrl_q;
      first_good = ref_q;
      for (int i = NUM_REF - 1; i >= 0; i--)
      begin
         if (!fail_w[i])
            first_good = 2'(i);
      end
      st_d  = st_q;
      ref_d = ref_q;
      case (mode_q)
         MODE_FREE: st_d = ST_FREE;
         MODE_HOLD:
            if (st_q == ST_NORM)
               st_d = ST_HOLD;
         MODE_NORMAL:
         begin
            ref_d = sel;
            if (!fail_w[sel])
               st_d = ST_NORM;
            else if (st_q == ST_NORM)
               st_d = ST_HOLD;
         end
         MODE_AUTO:
         begin
            // keep a good input, else take the first good one
            if (fail_w == 3'h7)
            begin
               if (st_q == ST_NORM)
                  st_d = ST_HOLD;
            end
            else
            begin
               ref_d = fail_w[ref_q] ? first_good : ref_q;
               st_d  = ST_NORM;
            end
         end
         default: st_d = ST_FREE;
      endcase
      // stored offset survives a same-input return unless hitless
      meas_d = (st_d == ST_NORM) &&
               ((st_q != ST_NORM && (hit_q || ref_d != ref_q)) ||
                (st_q == ST_NORM && ref_d != ref_q));
      cnt_d  = meas_d ? cnt_q + 16'h0001 : cnt_q;
      lock_d = (st_q == ST_NORM) && loop_locked_i;
      hold_d = (st_d == ST_HOLD);
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         mode_q <= MODE_NORMAL;
         st_q   <= ST_FREE;
         ref_q  <= 2'h0;
         lock_q <= 1'b0;
         hold_q <= 1'b0;
         meas_q <= 1'b0;
         cnt_q  <= COUNT_RST;
      end
      else
      begin
         mode_q <= mode_d;
         st_q   <= st_d;
         ref_q  <= ref_d;
         lock_q <= lock_d;
         hold_q <= hold_d;
         meas_q <= meas_d;
         cnt_q  <= cnt_d;
      end
   end

   assign loop_locked_o            = lock_q;
   assign coast_mode_o             = hold_q;
   assign active_input_o           = ref_q;
   assign offset_store_remeasure_o = meas_q;

   // ****************************************
   // axi4-lite write channel
   // ****************************************
   // address and data are parked until both arrived
   assign s_axi_awready = !aw_hold_q;
   assign s_axi_wready  = !w_hold_q;

   always_comb
   begin
      aw_hold_d = aw_hold_q;
      awaddr_d  = awaddr_q;
      w_hold_d  = w_hold_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      ctrl_d    = ctrl_q;
      if (s_axi_awvalid && !aw_hold_q)
      begin
         aw_hold_d = 1'b1;
         awaddr_d  = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_q)
      begin
         w_hold_d = 1'b1;
         wdata_d  = s_axi_wdata;
         wstrb_d  = s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready)
         bvalid_d = 1'b0;
      if (aw_hold_q && w_hold_q && !bvalid_q)
      begin
         aw_hold_d = 1'b0;
         w_hold_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = (awaddr_q == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
         if (awaddr_q == REG_CTRL && wstrb_q[0])
            ctrl_d = wdata_q[1:0];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         aw_hold_q <= 1'b0;
         awaddr_q  <= 8'h00;
         w_hold_q  <= 1'b0;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         ctrl_q    <= CTRL_RST;
      end
      else
      begin
         aw_hold_q <= aw_hold_d;
         awaddr_q  <= awaddr_d;
         w_hold_q  <= w_hold_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         ctrl_q    <= ctrl_d;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // ****************************************
   // axi4-lite read channel
   // ****************************************
   assign s_axi_arready = !rvalid_q;

   always_comb
   begin
      sts = 32'h00000000;
      sts[STS_LOCK]             = lock_q;
      sts[STS_HOLD]             = hold_q;
      sts[STS_FAIL +: 3]        = fail_w;
      sts[STS_STATE +: 2]       = 2'(st_q);
      sts[STS_REF +: 2]         = ref_q;
      sts[STS_MODE +: 2]        = mode_q;
      sts[STS_APP +: 2]         = app_q;
      sts[STS_HIT]              = hit_q;
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (rvalid_q && s_axi_rready)
         rvalid_d = 1'b0;
      if (s_axi_arvalid && !rvalid_q)
      begin
         rvalid_d = 1'b1;
         rresp_d  = RESP_OKAY;
         case (s_axi_araddr)
            REG_CTRL:   rdata_d = {30'h0, ctrl_q};
            REG_STATUS: rdata_d = sts;
            REG_COUNT:  rdata_d = {16'h0000, cnt_q};
            default:
            begin
               rdata_d = 32'h00000000;
               rresp_d = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= RESP_OKAY;
      end
      else
      begin
         rvalid_q <= rvalid_d;
         rdata_q  <= rdata_d;
         rresp_q  <= rresp_d;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

   // ****************************************
   // checks
   // ****************************************
   logic [16:0] mag_a;
   assign pins_mode = {op_mode_bit1_i, op_mode_bit0_i};
   assign mag_a = input_offset_i[0][15]
                ? (17'h0 - {1'b1, input_offset_i[0]})
                : {1'b0, input_offset_i[0]};

   sequence s_return_keep;
      (st_q != ST_NORM && !hit_q) ##1 (st_q == ST_NORM && $stable(ref_q));
   endsequence
   sequence s_return_hit;
      (st_q != ST_NORM && hit_q) ##1 (st_q == ST_NORM);
   endsequence

   chk_lock_rise: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      (st_q == ST_NORM && loop_locked_i) |=> loop_locked_o)
      else $error("lock not shown while locked in normal");
   chk_lock_drop: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      (st_q != ST_NORM) |=> !loop_locked_o)
      else $error("lock shown outside normal");
   chk_coast_level: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      coast_mode_o == (st_q == ST_HOLD))
      else $error("coast output disagrees with holdover");
   chk_keep_offset: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      s_return_keep |-> !offset_store_remeasure_o)
      else $error("offset remeasured on a plain return");
   chk_fresh_offset: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      s_return_hit |-> offset_store_remeasure_o)
      else $error("no remeasure on a hitless return");
   chk_mode_agree: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      $changed(mode_q) |-> (mode_q == $past(mode_s2_q) &&
                            mode_q == $past(mode_s3_q)))
      else $error("mode taken before both bits agreed");
   chk_auto_switch: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      (mode_q == MODE_AUTO && st_q == ST_NORM && fail_w[ref_q] &&
       fail_w != 3'h7) |=> (st_q == ST_NORM && ref_q != $past(ref_q)))
      else $error("automatic mode kept a failed input");
   chk_ds1_limit: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      (app_q == APP_DS1 && mag_a > {1'b0, THR_DS1}) |=> input_a_bad_flag_o)
      else $error("DS1 limit not applied");
   chk_e1_limit: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      (app_q == APP_E1 && !input_abrupt_i[0] &&
       mag_a <= {1'b0, THR_E1}) |=> !input_a_bad_flag_o)
      else $error("E1 limit not applied");
   chk_sync_depth: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      (!$past(sys_rst_i) && !$past(sys_rst_i, 2)) |->
         mode_s2_q == $past(pins_mode, 2))
      else $error("mode pins not synchronised by two stages");

endmodule

// [testbench/dmsp_board_ctl.sv]
`timescale 1ns/1ps
// ****************************************
// board controller on the select pins
// ****************************************
module dmsp_board_ctl
(
   input  wire logic       clk_i,          // master clock
   input  wire logic [1:0] mode_req_i,     // wanted mode code
   input  wire logic [1:0] app_req_i,      // wanted application code
   input  wire logic       hit_req_i,      // wanted hitless level
   output logic            op_mode_bit0_o, // mode pin 0
   output logic            op_mode_bit1_o, // mode pin 1
   output logic            app_bit0_o,     // application pin 0
   output logic            app_bit1_o,     // application pin 1
   output logic            hitless_o       // hitless pin
);
   // pins start low so the device never sees an unknown
   initial
   begin
      {op_mode_bit1_o, op_mode_bit0_o} = 2'h0;
      {app_bit1_o, app_bit0_o} = 2'h0;
      hitless_o = 1'b0;
   end
   // both mode bits move on one edge, so no mixed code is shown
   always @(posedge clk_i)
   begin
      {op_mode_bit1_o, op_mode_bit0_o} <= mode_req_i;
      {app_bit1_o, app_bit0_o} <= app_req_i;
      hitless_o <= hit_req_i;
   end
endmodule

// [testbench/dpll_mode_status_pins_tb_top.sv]
`timescale 1ns/1ps
module dpll_mode_status_pins_tb_top
   import dmsp_pkg::*;
   ;
   logic             clk_i = 1'b0;
   logic             sys_rst_i = 1'b1;
   logic [1:0]       mode_req = MODE_NORMAL;
   logic [1:0]       app_req = APP_DS1;
   logic             hit_req = 1'b0;
   logic             m0, m1, a0, a1, hit;
   logic             loop_locked_i = 1'b1;
   logic [2:0][15:0] offs = '0;
   logic [2:0]       abr = 3'h0;
   logic             lock, coast, remeas;
   logic [2:0]       bad;
   logic [1:0]       act;
   logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]      wdata = 32'h0, rdata;
   logic             awvalid = 0, wvalid = 0, bready = 0;
   logic             arvalid = 0, rready = 0;
   logic             awready, wready, bvalid, arready, rvalid;
   logic [1:0]       bresp, rresp;
   int               mismatches = 0;
   int               checked = 0;
   int               pulses = 0;

   // ****************************************
   // clock, partner, design
   // ****************************************
   always #2.5 clk_i = ~clk_i;
   dmsp_board_ctl board (.clk_i(clk_i), .mode_req_i(mode_req),
      .app_req_i(app_req), .hit_req_i(hit_req), .op_mode_bit0_o(m0),
      .op_mode_bit1_o(m1), .app_bit0_o(a0), .app_bit1_o(a1),
      .hitless_o(hit));
   dmsp_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .op_mode_bit0_i(m0), .op_mode_bit1_i(m1),
      .application_bit0_i(a0), .application_bit1_i(a1),
      .hitless_return_ctl_i(hit), .loop_locked_i(loop_locked_i),
      .input_offset_i(offs), .input_abrupt_i(abr),
      .loop_locked_o(lock), .coast_mode_o(coast),
      .input_a_bad_flag_o(bad[0]), .input_b_bad_flag_o(bad[1]),
      .input_c_bad_flag_o(bad[2]), .active_input_o(act),
      .offset_store_remeasure_o(remeas), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   // remeasure is a one-cycle pulse, so it is counted at every rising edge
   always @(posedge clk_i)
      if (remeas === 1'b1)
         pulses <= pulses + 1;

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: %s got %0h", $time, what, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // ready is looked at mid-cycle, where it has settled for the edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] resp);
      logic aw_go, w_go, b_go;
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      // no cycle budget here: only the watchdog ends a stuck wait
      forever
      begin
         @(negedge clk_i);
         aw_go = awvalid & awready;
         w_go = wvalid & wready;
         b_go = bvalid;
         resp = bresp;
         @(posedge clk_i);
         if (aw_go) awvalid <= 1'b0;
         if (w_go) wvalid <= 1'b0;
         if (b_go === 1'b1)
         begin
            bready <= 1'b0;
            return;
         end
      end
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] resp);
      logic ar_go, r_go;
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      forever
      begin
         @(negedge clk_i);
         ar_go = arvalid & arready;
         r_go = rvalid;
         d = rdata;
         resp = rresp;
         @(posedge clk_i);
         if (ar_go) arvalid <= 1'b0;
         if (r_go === 1'b1)
         begin
            rready <= 1'b0;
            return;
         end
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input logic [1:0] exp_r);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      chk(d, exp, "read data");
      chk({30'h0, r}, {30'h0, exp_r}, "read response");
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      @(negedge clk_i);
      chk({lock, coast, bad, act, remeas}, 32'h0, "outputs in reset");
      @(posedge clk_i);
      rd_chk(REG_CTRL, 32'h0, RESP_OKAY);
      cyc(10);
      chk({coast, lock}, 32'h1, "normal and locked");
      loop_locked_i <= 1'b0;
      cyc(3);
      chk(lock, 32'h0, "lock follows loop");
      loop_locked_i <= 1'b1;
      cyc(3);
   endtask
   task automatic t_hitless();
      int          p0;
      logic [31:0] c0;
      logic [1:0]  r;
      p0 = pulses;
      axi_rd(REG_COUNT, c0, r);
      mode_req <= MODE_HOLD;
      cyc(8);
      chk({coast, lock}, 32'h2, "holdover entered");
      mode_req <= MODE_NORMAL;
      cyc(8);
      chk(pulses, p0, "offset kept, no remeasure");
      chk({coast, lock}, 32'h1, "back to normal");
      hit_req <= 1'b1;
      mode_req <= MODE_FREE;
      cyc(8);
      chk({coast, lock}, 32'h0, "freerun shows neither");
      mode_req <= MODE_NORMAL;
      cyc(8);
      chk(pulses, p0 + 1, "remeasure from freerun");
      mode_req <= MODE_HOLD;
      cyc(8);
      mode_req <= MODE_NORMAL;
      cyc(8);
      chk(pulses, p0 + 2, "remeasure from holdover");
      rd_chk(REG_COUNT, c0 + 32'h2, RESP_OKAY);
      hit_req <= 1'b0;
   endtask
   task automatic t_limits();
      logic [15:0] lim [4] = '{THR_DS1, THR_E1, THR_WIDE, THR_WIDE};
      for (int i = 0; i < 4; i++)
      begin
         app_req <= i[1:0];
         offs <= {16'h0 - lim[i] - 16'h1, lim[i] + 16'h1, lim[i]};
         cyc(6);
         chk(bad, 32'h6, "range limit per application");
      end
      app_req <= APP_DS1;
      offs <= '0;
      abr <= 3'h5;
      cyc(6);
      chk(bad, 32'h5, "abrupt change flags");
      abr <= 3'h0;
      cyc(8);
      chk({bad, coast}, 32'h0, "flags clear again");
   endtask
   task automatic t_auto();
      mode_req <= MODE_AUTO;
      offs[0] <= 16'h0200;
      cyc(8);
      chk(act, 32'h1, "auto moves to input b");
      // selected input fails while locked, input c still good
      abr <= 3'h2;
      cyc(6);
      chk(act, 32'h2, "auto leaves failed input b");
      abr <= 3'h6;
      cyc(6);
      chk({coast, lock}, 32'h2, "auto with none good holds");
      abr <= 3'h0;
      offs <= '0;
      mode_req <= MODE_NORMAL;
      cyc(10);
   endtask
   task automatic t_regs();
      logic [1:0] r;
      axi_wr(REG_STATUS, 32'h1, r);
      chk(r, RESP_SLVERR, "write to read-only");
      rd_chk(8'h0C, 32'h0, RESP_SLVERR);
      axi_wr(REG_CTRL, 32'h2, r);
      chk(r, RESP_OKAY, "control write");
      rd_chk(REG_CTRL, 32'h2, RESP_OKAY);
      cyc(8);
      chk(act, 32'h2, "manual pick of input c");
      rd_chk(REG_STATUS, 32'h0000_0121, RESP_OKAY);
      axi_wr(REG_CTRL, 32'h3, r);
      cyc(6);
      chk(act, 32'h0, "select code 3 falls back to input a");
   endtask
   task automatic give_verdict();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // main sequence after two cycles of reset
   initial
   begin
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_hitless();
      t_limits();
      t_auto();
      t_regs();
      give_verdict();
   end
   // the run needs well under a thousand cycles
   initial
   begin
      #(5 * 5000);
      mismatches++;
      give_verdict();
   end
endmodule
